// ### src/fdc_map.vh
// Register offsets, reset values and range limits of the fan drive
// configuration bank. Definitions only; included by the register bank and its checker.
`ifndef FDC_MAP_VH
`define FDC_MAP_VH

// ----------------------------------------------------------------------
// Holding register offsets
// ----------------------------------------------------------------------
`define FDC_OFF_CURRENT_LIMIT  16'h0007
`define FDC_OFF_THR_LOW        16'h0010
`define FDC_OFF_FIXED_SPEED    16'h0015
`define FDC_OFF_SLIP           16'h001E
`define FDC_OFF_POLARITY       16'h001F
`define FDC_OFF_SKIP_START     16'h0020
`define FDC_OFF_SKIP_END       16'h0021
`define FDC_OFF_MODE           16'h0022
`define FDC_OFF_POWER_LIMIT    16'h0024
`define FDC_OFF_AIRFLOW        16'h0027
`define FDC_OFF_AIRFLOW_FLOOR  16'h002A

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FDC_RST_THR_LOW        16'h0000
`define FDC_RST_FIXED_SPEED    16'h0000
`define FDC_RST_SLIP           16'h0000
`define FDC_RST_POLARITY       16'h0000
`define FDC_RST_SKIP_START     16'h4E20
`define FDC_RST_SKIP_END       16'h4E20
`define FDC_RST_MODE           16'h0001
`define FDC_RST_AIRFLOW        16'h0000

// ----------------------------------------------------------------------
// Range limits and field positions
// ----------------------------------------------------------------------
`define FDC_MODE_MAX           16'h000C
`define FDC_SLIP_MAX           16'h0064
`define FDC_SKIP_MAX           16'h4E20
`define FDC_POWER_MIN          16'h000A
`define FDC_POLARITY_MAX       16'h0001
`define FDC_DOUT_BAND          16'h0003
`define FDC_MODE_FIXED_SPEED   16'h0002
`define FDC_MODE_FIXED_AIR     16'h0006
`define FDC_MODE_FIXED_SLIP    16'h0009
`define FDC_MODE_FIXED_REF     16'h000C
`define FDC_MODE_FOLLOW        16'h0003
`define FDC_POLARITY_BIT       0

`endif

// ### src/fdc_band_mon.v
// Speed band monitor: flags whether the running fan sits inside the band
// set by the low and high thresholds.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps

module fdc_band_mon
(
  // Clock and reset.
  input  wire        i_clk,
  input  wire        i_arst_n,
  // Band limits and measured state.
  input  wire        i_enable,
  input  wire        i_running,
  input  wire [15:0] i_speed,
  input  wire [15:0] i_low,
  input  wire [15:0] i_high,
  // Result.
  output reg         o_in_band
);

  // ----------------------------------------------------------------------
  // Band compare
  // ----------------------------------------------------------------------

  // A stopped fan is never reported in band, even with a zero low limit.
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_in_band <= 1'b0;
    else
      o_in_band <= i_enable & i_running &
                   (i_speed >= i_low) & (i_speed <= i_high);
  end

endmodule

// ### src/fdc_regs.v
// Fan drive configuration bank: mode selector, setpoint registers, speed
// band and skip limits, power, current and airflow limits.
// Assumes a protocol front end on I_CLK that presents one holding register
// access at a time; limits kept outside this bank arrive as same-clock inputs.
//
// How it works
// - Mode selector takes 0..12, resets to 1.
// - Modes 0..2 take speed from 66/analog/21.
// - Mode 3 follows the leading fan's command.
// - Modes 4..6 airflow from analog/66/39.
// - Modes 7..9 emulation from analog/66/30.
// - Modes 10..12 regulator reference analog/66/50.
// - Low threshold used only when output function 3.
// - Fixed speed used in mode 2, min..max.
// - Slip takes 0..100, used in mode 9.
// - Polarity takes 0 or 1; 1 inverts feedback.
// - Skip start 0..end, resets to 20000.
// - Skip end start..20000, resets to 20000.
// - Power limit 10..rating default, lowers only.
// - Airflow setpoint used in mode 6, floor..max.
// - Airflow floor from model default up to max.
// - Current limit may only be lowered.
// - Function 3 output flags speed inside band.
`timescale 1ns/1ps
`include "fdc_map.vh"

module fdc_regs
#(
  parameter [15:0] POWER_DEFAULT   = 16'd1050,
  parameter [15:0] CURRENT_DEFAULT = 16'd6000,
  parameter [15:0] FLOOR_DEFAULT   = 16'd500
)
(
  // Clock and reset.
  input  wire        I_CLK,
  input  wire        I_ARST_N,
  // Holding register access.
  input  wire        I_WR,
  input  wire        I_RD,
  input  wire [15:0] I_ADDR,
  input  wire [15:0] I_WDATA,
  output reg  [15:0] O_RDATA,
  output reg         O_ACK,
  output reg         O_ERR,
  // Limits and values held outside this bank.
  input  wire [15:0] I_MIN_SPEED,
  input  wire [15:0] I_MAX_SPEED,
  input  wire [15:0] I_MAX_AIRFLOW,
  input  wire [15:0] I_THR_HIGH,
  input  wire [15:0] I_DOUT_FUNC,
  input  wire [15:0] I_HOST_SETPOINT,
  input  wire [15:0] I_EXT_SETPOINT,
  // Live drive inputs.
  input  wire [15:0] I_ANALOG_IN,
  input  wire [15:0] I_FOLLOW_CMD,
  input  wire [15:0] I_MEAS_SPEED,
  input  wire        I_RUNNING,
  // Drive control outputs.
  output reg  [3:0]  O_MODE,
  output reg  [1:0]  O_TARGET_KIND,
  output reg  [1:0]  O_TARGET_SRC,
  output reg  [15:0] O_TARGET,
  output reg         O_FEEDBACK_INV,
  output reg  [15:0] O_SKIP_START,
  output reg  [15:0] O_SKIP_END,
  output reg  [15:0] O_POWER_LIMIT,
  output reg  [15:0] O_CURRENT_LIMIT,
  output reg  [15:0] O_AIRFLOW_FLOOR,
  output reg  [15:0] O_SLIP,
  output wire        O_IN_BAND
);

  // Target source codes.
  localparam [1:0] SRC_HOST   = 2'h0;
  localparam [1:0] SRC_ANALOG = 2'h1;
  localparam [1:0] SRC_FIXED  = 2'h2;
  localparam [1:0] SRC_FOLLOW = 2'h3;
  // Target kinds.
  localparam [1:0] KIND_SPEED = 2'h0;
  localparam [1:0] KIND_AIR   = 2'h1;
  localparam [1:0] KIND_EMUL  = 2'h2;
  localparam [1:0] KIND_LOOP  = 2'h3;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  reg  [15:0] thr_low_reg;
  reg  [15:0] fixed_speed_reg;
  reg  [15:0] slip_reg;
  reg  [15:0] polarity_reg;
  reg  [15:0] skip_start_reg;
  reg  [15:0] skip_end_reg;
  reg  [15:0] mode_reg;
  reg  [15:0] power_reg;
  reg  [15:0] current_reg;
  reg  [15:0] airflow_reg;
  reg  [15:0] floor_reg;

  wire        access = I_WR | I_RD;
  wire        mapped;
  wire        wr_ok;
  reg  [15:0] rd_next;
  reg  [1:0]  src_next;
  reg  [1:0]  kind_next;
  reg  [15:0] target_next;
  reg  [15:0] raw_target;
  reg         range_ok;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------

  // Address decode, used only for the error flag of the answer.
  function is_mapped;
    input [15:0] addr;
    begin
      case (addr)
        `FDC_OFF_CURRENT_LIMIT, `FDC_OFF_THR_LOW, `FDC_OFF_FIXED_SPEED,
        `FDC_OFF_SLIP, `FDC_OFF_POLARITY, `FDC_OFF_SKIP_START,
        `FDC_OFF_SKIP_END, `FDC_OFF_MODE, `FDC_OFF_POWER_LIMIT,
        `FDC_OFF_AIRFLOW, `FDC_OFF_AIRFLOW_FLOOR:
          is_mapped = 1'b1;
        default:
          is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Range check of a write; limits that hinge on other registers use their
  // present values, so a pair must be widened in the right order. Kept as a
  // process so that every limit it reads wakes it up when it changes.
  always @*
  begin
    case (I_ADDR)
      `FDC_OFF_MODE:          range_ok = (I_WDATA <= `FDC_MODE_MAX);
      `FDC_OFF_THR_LOW:       range_ok = (I_WDATA <= I_THR_HIGH);
      `FDC_OFF_FIXED_SPEED:   range_ok = (I_WDATA >= I_MIN_SPEED) &
                                         (I_WDATA <= I_MAX_SPEED);
      `FDC_OFF_SLIP:          range_ok = (I_WDATA <= `FDC_SLIP_MAX);
      `FDC_OFF_POLARITY:      range_ok = (I_WDATA <= `FDC_POLARITY_MAX);
      `FDC_OFF_SKIP_START:    range_ok = (I_WDATA <= skip_end_reg);
      `FDC_OFF_SKIP_END:      range_ok = (I_WDATA >= skip_start_reg) &
                                         (I_WDATA <= `FDC_SKIP_MAX);
      `FDC_OFF_POWER_LIMIT:   range_ok = (I_WDATA >= `FDC_POWER_MIN) &
                                         (I_WDATA <= POWER_DEFAULT);
      `FDC_OFF_CURRENT_LIMIT: range_ok = (I_WDATA <= CURRENT_DEFAULT);
      `FDC_OFF_AIRFLOW:       range_ok = (I_WDATA >= floor_reg) &
                                         (I_WDATA <= I_MAX_AIRFLOW);
      `FDC_OFF_AIRFLOW_FLOOR: range_ok = (I_WDATA >= FLOOR_DEFAULT) &
                                         (I_WDATA <= I_MAX_AIRFLOW);
      default:                range_ok = 1'b0;
    endcase
  end

  assign mapped = is_mapped(I_ADDR);
  assign wr_ok  = I_WR & range_ok;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------

  // A rejected write leaves every register as it was.
  always @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      thr_low_reg     <= `FDC_RST_THR_LOW;
      fixed_speed_reg <= `FDC_RST_FIXED_SPEED;
      slip_reg        <= `FDC_RST_SLIP;
      polarity_reg    <= `FDC_RST_POLARITY;
      skip_start_reg  <= `FDC_RST_SKIP_START;
      skip_end_reg    <= `FDC_RST_SKIP_END;
      mode_reg        <= `FDC_RST_MODE;
      power_reg       <= POWER_DEFAULT;
      current_reg     <= CURRENT_DEFAULT;
      airflow_reg     <= `FDC_RST_AIRFLOW;
      floor_reg       <= FLOOR_DEFAULT;
    end
    else if (wr_ok)
    begin
      case (I_ADDR)
        `FDC_OFF_THR_LOW:       thr_low_reg     <= I_WDATA;
        `FDC_OFF_FIXED_SPEED:   fixed_speed_reg <= I_WDATA;
        `FDC_OFF_SLIP:          slip_reg        <= I_WDATA;
        `FDC_OFF_POLARITY:      polarity_reg    <= I_WDATA;
        `FDC_OFF_SKIP_START:    skip_start_reg  <= I_WDATA;
        `FDC_OFF_SKIP_END:      skip_end_reg    <= I_WDATA;
        `FDC_OFF_MODE:          mode_reg        <= I_WDATA;
        `FDC_OFF_POWER_LIMIT:   power_reg       <= I_WDATA;
        `FDC_OFF_CURRENT_LIMIT: current_reg     <= I_WDATA;
        `FDC_OFF_AIRFLOW:       airflow_reg     <= I_WDATA;
        `FDC_OFF_AIRFLOW_FLOOR: floor_reg       <= I_WDATA;
        default:                thr_low_reg     <= thr_low_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read mux and answer
  // ----------------------------------------------------------------------

  // Unmapped addresses read as zero.
  always @*
  begin
    case (I_ADDR)
      `FDC_OFF_THR_LOW:       rd_next = thr_low_reg;
      `FDC_OFF_FIXED_SPEED:   rd_next = fixed_speed_reg;
      `FDC_OFF_SLIP:          rd_next = slip_reg;
      `FDC_OFF_POLARITY:      rd_next = polarity_reg;
      `FDC_OFF_SKIP_START:    rd_next = skip_start_reg;
      `FDC_OFF_SKIP_END:      rd_next = skip_end_reg;
      `FDC_OFF_MODE:          rd_next = mode_reg;
      `FDC_OFF_POWER_LIMIT:   rd_next = power_reg;
      `FDC_OFF_CURRENT_LIMIT: rd_next = current_reg;
      `FDC_OFF_AIRFLOW:       rd_next = airflow_reg;
      `FDC_OFF_AIRFLOW_FLOOR: rd_next = floor_reg;
      default:                rd_next = 16'h0000;
    endcase
  end

  // One answer per access, one cycle later; a write wins over a read.
  always @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_ACK   <= 1'b0;
      O_ERR   <= 1'b0;
      O_RDATA <= 16'h0000;
    end
    else
    begin
      O_ACK   <= access;
      O_ERR   <= access & (!mapped | (I_WR & !wr_ok));
      O_RDATA <= (I_RD & !I_WR) ? rd_next : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Target selection
  // ----------------------------------------------------------------------

  // Modes 4..12 come in groups of three: analog, host register, fixed one.
  // Kind, source and raw value are decoded apart so each table stays short.
  always @*
  begin
    case (mode_reg)
      16'h0004, 16'h0005, `FDC_MODE_FIXED_AIR:  kind_next = KIND_AIR;
      16'h0007, 16'h0008, `FDC_MODE_FIXED_SLIP: kind_next = KIND_EMUL;
      16'h000A, 16'h000B, `FDC_MODE_FIXED_REF:  kind_next = KIND_LOOP;
      default:                                  kind_next = KIND_SPEED;
    endcase
    case (mode_reg)
      16'h0000, 16'h0005, 16'h0008, 16'h000B:    src_next = SRC_HOST;
      `FDC_MODE_FIXED_SPEED, `FDC_MODE_FIXED_AIR,
      `FDC_MODE_FIXED_SLIP, `FDC_MODE_FIXED_REF: src_next = SRC_FIXED;
      `FDC_MODE_FOLLOW:                          src_next = SRC_FOLLOW;
      default:                                   src_next = SRC_ANALOG;
    endcase
    case (mode_reg)
      16'h0000, 16'h0005, 16'h0008, 16'h000B: raw_target = I_HOST_SETPOINT;
      `FDC_MODE_FIXED_SPEED:                  raw_target = fixed_speed_reg;
      `FDC_MODE_FOLLOW:                       raw_target = I_FOLLOW_CMD;
      `FDC_MODE_FIXED_AIR:                    raw_target = airflow_reg;
      `FDC_MODE_FIXED_SLIP:                   raw_target = slip_reg;
      `FDC_MODE_FIXED_REF:                    raw_target = I_EXT_SETPOINT;
      default:                                raw_target = I_ANALOG_IN;
    endcase
    // Speed targets inside the resonance band drop to its lower edge.
    if ((kind_next == KIND_SPEED) && (raw_target > skip_start_reg) &&
        (raw_target < skip_end_reg))
      target_next = skip_start_reg;
    else
      target_next = raw_target;
  end

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------

  // Values follow the registers one cycle later and the target tracks the live inputs;
  // the master is expected to write with the fan stopped, so no glitch-free handover is made.
  always @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_MODE          <= 4'h1;
      O_TARGET_KIND   <= KIND_SPEED;
      O_TARGET_SRC    <= SRC_ANALOG;
      O_TARGET        <= 16'h0000;
      O_FEEDBACK_INV  <= 1'b0;
      O_SKIP_START    <= `FDC_RST_SKIP_START;
      O_SKIP_END      <= `FDC_RST_SKIP_END;
      O_POWER_LIMIT   <= POWER_DEFAULT;
      O_CURRENT_LIMIT <= CURRENT_DEFAULT;
      O_AIRFLOW_FLOOR <= FLOOR_DEFAULT;
      O_SLIP          <= `FDC_RST_SLIP;
    end
    else
    begin
      O_MODE          <= mode_reg[3:0];
      O_TARGET_KIND   <= kind_next;
      O_TARGET_SRC    <= src_next;
      O_TARGET        <= target_next;
      O_FEEDBACK_INV  <= polarity_reg[`FDC_POLARITY_BIT];
      O_SKIP_START    <= skip_start_reg;
      O_SKIP_END      <= skip_end_reg;
      O_POWER_LIMIT   <= power_reg;
      O_CURRENT_LIMIT <= current_reg;
      O_AIRFLOW_FLOOR <= floor_reg;
      O_SLIP          <= (mode_reg == `FDC_MODE_FIXED_SLIP) ?
                         slip_reg : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Speed band indication
  // ----------------------------------------------------------------------

  // The low threshold only matters when the output is in band mode.
  fdc_band_mon u_band
  (
    .i_clk     (I_CLK),
    .i_arst_n  (I_ARST_N),
    .i_enable  (I_DOUT_FUNC == `FDC_DOUT_BAND),
    .i_running (I_RUNNING),
    .i_speed   (I_MEAS_SPEED),
    .i_low     (thr_low_reg),
    .i_high    (I_THR_HIGH),
    .o_in_band (O_IN_BAND)
  );

endmodule

// ### tb/fdc_bus_master.sv
// Bus master model standing for the serial protocol layer.
// Assumes the bank's clock; it drives on the falling edge.
`timescale 1ns/1ps
module fdc_bus_master
(
  // Clock.
  input  wire        clk,
  // Register port.
  output reg         wr,
  output reg         rd,
  output reg  [15:0] addr,
  output reg  [15:0] wdata,
  input  wire [15:0] rdata,
  input  wire        ack,
  input  wire        err
);
  // Idle at time zero so nothing is taken during reset.
  initial
  begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
  end

  // One pulse per access, answer taken one cycle later. Released lines
  // show the inverse so a stale address is never taken for a live one.
  task xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
            output logic [15:0] q, output logic e, output logic k);
    begin
      @(negedge clk);
      wr = w;
      rd = !w;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      addr = ~a;
      wdata = ~d;
      q = rdata;
      e = err;
      k = ack;
    end
  endtask
endmodule

// ### tb/fdc_regs_asserts.sv
// Checker for the configuration bank, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`include "fdc_map.vh"
module fdc_regs_chk
#(
  parameter [15:0] POWER_DEFAULT   = 16'h041A,
  parameter [15:0] CURRENT_DEFAULT = 16'h1770
)
(
  input wire        I_CLK,
  input wire        I_ARST_N,
  input wire        I_WR,
  input wire [15:0] I_ADDR,
  input wire [15:0] I_WDATA,
  input wire [15:0] I_DOUT_FUNC,
  input wire        I_RUNNING,
  input wire [15:0] I_ANALOG_IN,
  input wire        O_ACK,
  input wire        O_ERR,
  input wire [3:0]  O_MODE,
  input wire [1:0]  O_TARGET_KIND,
  input wire [1:0]  O_TARGET_SRC,
  input wire [15:0] O_TARGET,
  input wire        O_FEEDBACK_INV,
  input wire [15:0] O_SKIP_START,
  input wire [15:0] O_SKIP_END,
  input wire [15:0] O_POWER_LIMIT,
  input wire [15:0] O_CURRENT_LIMIT,
  input wire [15:0] O_SLIP,
  input wire        O_IN_BAND
);
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);

  // A refused mode write answers with an error and the mode output holds for the cycle after.
  sequence s_bad_mode;
    I_WR && I_ADDR == `FDC_OFF_MODE && I_WDATA > `FDC_MODE_MAX;
  endsequence
  sequence s_refused;
    O_ACK && O_ERR ##1 $stable(O_MODE);
  endsequence

  AST_MODE_MAX: assert property (O_MODE <= 4'hC)
    else $error("mode output above the last mode");
  AST_MODE_REFUSE: assert property (s_bad_mode |=> s_refused)
    else $error("bad mode write not refused");
  AST_ERR_ACK: assert property (O_ERR |-> O_ACK)
    else $error("error without answer");
  AST_SLIP_MAX: assert property (O_SLIP <= 16'h0064)
    else $error("slip above its top");
  AST_SLIP_GATE: assert property (O_SLIP != 16'h0000 |-> O_MODE == 4'h9)
    else $error("slip used outside its mode");
  AST_POLARITY: assert property (I_WR && I_ADDR == `FDC_OFF_POLARITY &&
    I_WDATA == 16'h0001 |-> ##2 O_FEEDBACK_INV)
    else $error("feedback not inverted");
  AST_SKIP_ORDER: assert property (O_SKIP_START <= O_SKIP_END &&
    O_SKIP_END <= `FDC_SKIP_MAX)
    else $error("skip band out of order");
  AST_POWER_RANGE: assert property (O_POWER_LIMIT >= 16'h000A &&
    O_POWER_LIMIT <= POWER_DEFAULT)
    else $error("power limit out of range");
  AST_CURRENT_MAX: assert property (O_CURRENT_LIMIT <= CURRENT_DEFAULT)
    else $error("current limit raised");
  AST_BAND_GATE: assert property (O_IN_BAND |->
    $past(I_DOUT_FUNC) == 16'h0003 && $past(I_RUNNING))
    else $error("band flag without its function");
  AST_AIR_ANALOG: assert property (O_MODE == 4'h4 |-> O_TARGET_KIND == 2'h1 &&
    O_TARGET_SRC == 2'h1 && O_TARGET == $past(I_ANALOG_IN))
    else $error("airflow target not from analog input");
endmodule

bind fdc_regs fdc_regs_chk
#(
  .POWER_DEFAULT(POWER_DEFAULT),
  .CURRENT_DEFAULT(CURRENT_DEFAULT)
)
u_chk
(
  .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_WR(I_WR), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_DOUT_FUNC(I_DOUT_FUNC), .I_RUNNING(I_RUNNING),
  .I_ANALOG_IN(I_ANALOG_IN), .O_ACK(O_ACK), .O_ERR(O_ERR), .O_MODE(O_MODE),
  .O_TARGET_KIND(O_TARGET_KIND), .O_TARGET_SRC(O_TARGET_SRC),
  .O_TARGET(O_TARGET), .O_FEEDBACK_INV(O_FEEDBACK_INV),
  .O_SKIP_START(O_SKIP_START), .O_SKIP_END(O_SKIP_END),
  .O_POWER_LIMIT(O_POWER_LIMIT), .O_CURRENT_LIMIT(O_CURRENT_LIMIT),
  .O_SLIP(O_SLIP), .O_IN_BAND(O_IN_BAND)
);

// ### tb/fan_drive_config_registers_tb.sv
// Self-checking bench for the configuration bank.
// Assumes the master model beside it and the checker bound to the bank.
`timescale 1ns/1ps
module fan_drive_config_registers_tb;
  logic        clk;
  logic        rst_n;
  logic        run;
  logic [15:0] dout, host, ana, fol, ext, spd;
  wire         wr, rd, ack, err, inv, band;
  wire  [15:0] ad, wd, rdat, tgt, sks, ske, pwr, cur, flr, slip;
  wire  [3:0]  mode;
  wire  [1:0]  kind, src;
  int          n_mismatch;
  int          comparisons;

  // Address, data, refused, read-back value.
  localparam logic [48:0] RT [23] = '{
    {16'h001E,16'h0065,1'b1,16'h0000}, {16'h001E,16'h0064,1'b0,16'h0064},
    {16'h001E,16'h0032,1'b0,16'h0032}, {16'h001F,16'h0002,1'b1,16'h0000},
    {16'h0024,16'h0009,1'b1,16'h041A}, {16'h0024,16'h041B,1'b1,16'h041A},
    {16'h0024,16'h000A,1'b0,16'h000A}, {16'h0007,16'h1771,1'b1,16'h1770},
    {16'h0007,16'h1770,1'b0,16'h1770}, {16'h0010,16'h07D1,1'b1,16'h0000},
    {16'h0010,16'h0064,1'b0,16'h0064}, {16'h0015,16'h0063,1'b1,16'h0000},
    {16'h0015,16'h0BB9,1'b1,16'h0000}, {16'h0015,16'h03E8,1'b0,16'h03E8},
    {16'h002A,16'h01F3,1'b1,16'h01F4}, {16'h0027,16'h01F3,1'b1,16'h0000},
    {16'h0027,16'h02BC,1'b0,16'h02BC}, {16'h0020,16'h03E8,1'b0,16'h03E8},
    {16'h0021,16'h4E21,1'b1,16'h4E20}, {16'h0021,16'h07D0,1'b0,16'h07D0},
    {16'h0020,16'h07D1,1'b1,16'h03E8}, {16'h0022,16'h000D,1'b1,16'h0001},
    {16'h0001,16'h0005,1'b1,16'h0000}};
  localparam logic [31:0] RV [11] = '{
    {16'h0010,16'h0000}, {16'h0015,16'h0000}, {16'h001E,16'h0000},
    {16'h001F,16'h0000}, {16'h0020,16'h4E20}, {16'h0021,16'h4E20},
    {16'h0022,16'h0001}, {16'h0024,16'h041A}, {16'h0027,16'h0000},
    {16'h002A,16'h01F4}, {16'h0007,16'h1770}};
  localparam logic [15:0] MT [13] = '{16'h00C8, 16'h0064, 16'h03E8, 16'h012C,
    16'h0064, 16'h00C8, 16'h02BC, 16'h0064, 16'h00C8, 16'h0032, 16'h0064,
    16'h00C8, 16'h0190};
  localparam logic [25:0] MS = 26'h21861E4;

  fdc_bus_master u_mst
  (
    .clk(clk), .wr(wr), .rd(rd), .addr(ad), .wdata(wd), .rdata(rdat),
    .ack(ack), .err(err)
  );

  fdc_regs u_dut
  (
    .I_CLK(clk), .I_ARST_N(rst_n), .I_WR(wr), .I_RD(rd), .I_ADDR(ad),
    .I_WDATA(wd), .O_RDATA(rdat), .O_ACK(ack), .O_ERR(err),
    .I_MIN_SPEED(16'h0064), .I_MAX_SPEED(16'h0BB8), .I_MAX_AIRFLOW(16'h1388),
    .I_THR_HIGH(16'h07D0), .I_DOUT_FUNC(dout), .I_HOST_SETPOINT(host),
    .I_EXT_SETPOINT(ext), .I_ANALOG_IN(ana), .I_FOLLOW_CMD(fol),
    .I_MEAS_SPEED(spd), .I_RUNNING(run), .O_MODE(mode), .O_TARGET_KIND(kind),
    .O_TARGET_SRC(src), .O_TARGET(tgt), .O_FEEDBACK_INV(inv),
    .O_SKIP_START(sks), .O_SKIP_END(ske), .O_POWER_LIMIT(pwr),
    .O_CURRENT_LIMIT(cur), .O_AIRFLOW_FLOOR(flr), .O_SLIP(slip),
    .O_IN_BAND(band)
  );

  // --------------------
  // Checks and bus access
  // --------------------
  task chk16(input logic [15:0] g, input logic [15:0] x);
    begin
      comparisons++;
      if (g !== x)
      begin
        n_mismatch++;
        $display("wrong value at %0t: got %h want %h", $time, g, x);
      end
    end
  endtask

  task chk1(input logic g, input logic x);
    begin
      chk16({15'h0000, g}, {15'h0000, x});
    end
  endtask

  // Every access must be answered, with the error flag as expected.
  task acc(input logic w, input logic [15:0] a, input logic [15:0] d,
           input logic ee, output logic [15:0] q);
    logic e, k;
    begin
      u_mst.xfer(w, a, d, q, e, k);
      chk1(k, 1'b1);
      chk1(e, ee);
    end
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task t_reset;
    logic [15:0] q;
    begin
      for (int i = 0; i < 11; i++)
      begin
        acc(1'b0, RV[i][31:16], 16'h0000, 1'b0, q);
        chk16(q, RV[i][15:0]);
      end
    end
  endtask

  // Boundary and refused writes; read-back proves a refusal kept the value.
  task t_ranges;
    logic [15:0] q;
    begin
      for (int i = 0; i < 23; i++)
      begin
        acc(1'b1, RT[i][48:33], RT[i][32:17], RT[i][16], q);
        acc(1'b0, RT[i][48:33], 16'h0000, RT[i][48:33] == 16'h0001, q);
        chk16(q, RT[i][15:0]);
      end
    end
  endtask

  task t_modes;
    logic [15:0] q;
    logic [1:0]  k;
    begin
      for (int m = 0; m < 13; m++)
      begin
        k = (m < 4) ? 2'h0 : (m < 7) ? 2'h1 : (m < 10) ? 2'h2 : 2'h3;
        acc(1'b1, 16'h0022, m[15:0], 1'b0, q);
        @(negedge clk);
        chk16({12'h000, mode}, m[15:0]);
        chk16({14'h0000, kind}, {14'h0000, k});
        chk16({14'h0000, src}, {14'h0000, MS[2*m +: 2]});
        chk16(tgt, MT[m]);
        chk16(slip, (m == 9) ? 16'h0032 : 16'h0000);
      end
    end
  endtask

  task t_skip;
    logic [15:0] q;
    begin
      acc(1'b1, 16'h0022, 16'h0000, 1'b0, q);
      host = 16'h05DC;
      @(negedge clk);
      @(negedge clk);
      chk16(tgt, 16'h03E8);
      host = 16'h07D0;
      @(negedge clk);
      chk16(tgt, 16'h07D0);
      chk16(sks, 16'h03E8);
      chk16(ske, 16'h07D0);
      chk16(pwr, 16'h000A);
      chk16(cur, 16'h1770);
      chk16(flr, 16'h01F4);
    end
  endtask

  task t_band;
    begin
      dout = 16'h0003;
      run = 1'b1;
      @(negedge clk);
      chk1(band, 1'b1);
      spd = 16'h07D1;
      @(negedge clk);
      chk1(band, 1'b0);
      spd = 16'h07D0;
      @(negedge clk);
      chk1(band, 1'b1);
      spd = 16'h0032;
      @(negedge clk);
      chk1(band, 1'b0);
      spd = 16'h01F4;
      dout = 16'h0002;
      @(negedge clk);
      chk1(band, 1'b0);
      dout = 16'h0003;
      run = 1'b0;
      @(negedge clk);
      chk1(band, 1'b0);
    end
  endtask

  task t_polarity;
    logic [15:0] q;
    begin
      acc(1'b1, 16'h001F, 16'h0001, 1'b0, q);
      @(negedge clk);
      chk1(inv, 1'b1);
      acc(1'b1, 16'h001F, 16'h0000, 1'b0, q);
      @(negedge clk);
      chk1(inv, 1'b0);
    end
  endtask

  // A reset in mid-run brings back the defaults on outputs and registers.
  task t_rearm;
    logic [15:0] q;
    begin
      rst_n = 1'b0;
      @(negedge clk);
      chk16({12'h000, mode}, 16'h0001);
      chk16({14'h0000, src}, 16'h0001);
      chk16(sks, 16'h4E20);
      chk16(ske, 16'h4E20);
      chk16(pwr, 16'h041A);
      chk1(band, 1'b0);
      rst_n = 1'b1;
      acc(1'b0, 16'h0010, 16'h0000, 1'b0, q);
      chk16(q, 16'h0000);
    end
  endtask

  task results;
    begin
      if (n_mismatch == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The fan stays stopped whenever the master writes.
  initial
  begin
    n_mismatch = 0;
    comparisons = 0;
    rst_n = 1'b0;
    run = 1'b0;
    dout = 16'h0000;
    host = 16'h00C8;
    ana = 16'h0064;
    fol = 16'h012C;
    ext = 16'h0190;
    spd = 16'h01F4;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_ranges;
    t_modes;
    t_skip;
    t_band;
    t_polarity;
    t_rearm;
    results;
  end

  // The whole run needs under two hundred cycles; this limit is generous.
  initial
  begin
    #50000;
    n_mismatch++;
    results;
  end
endmodule
